// file: cfp_card_ctrl.v
`timescale 1ns/1ns
`include "cfp_defs.vh"

// Contract
// - Idle session: fault/absent output follows debounced card presence.
// - Logic supply drop outside session pulses internal reset, output untouched.
// - Overcurrent and overtemperature ignored while no session is active.
// - Session fault drives output low and starts emergency deactivation.
// - After fault deactivation with request released, output shows presence.
// - Card switch debounced for about 8 ms.
// - Insertion raises output only after stable debounce interval.
// - Extraction acts on first falling switch edge, no debounce.
// - No low-power stop mode exists; only osc_fast drops, in idle.
// - Supply select high chooses 5V card supply.
// - Supply select low chooses 3V, regardless of activation.
// - Request low: supply 1.5T, data lines 4T, reset 7T.
// - Deactivation: reset, clock at 0.5T, data at T, supply 1.5T.
module cfp_card_ctrl #(
  parameter DEB_CYCLES = `CFP_DEB_CYCLES,
  parameter OSC_DIV = `CFP_OSC_DIV
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Host lines
  input wire session_request_n,
  input wire supply_level_select,
  input wire host_reset_in,
  output wire fault_absent_n,
  // Card switch and supervisors
  input wire card_present_switch,
  input wire overcurrent,
  input wire overtemp,
  input wire vdd_low,
  input wire vcc_out_of_range,
  input wire vcc_discharged,
  // Card side controls
  output wire vcc_enable,
  output wire vcc_sel_5v,
  output wire io_enable,
  output wire card_clk_enable,
  output wire card_rst,
  output wire osc_fast,
  output wire por_pulse,
  // Interrupt
  output wire irq
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ACT = 4'h2;
  localparam [3:0] ST_ACTIVE = 4'h4;
  localparam [3:0] ST_DEACT = 4'h8;
  localparam [31:0] OSC_DIV_W = OSC_DIV;
  localparam [7:0] OSC_LAST = OSC_DIV_W[7:0] - 8'h01;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [7:0] div_ff;
  reg [4:0] tick_ff;
  reg [3:0] step_ff;
  reg vcc_en_ff;
  reg nxt_vcc_en;
  reg io_en_ff;
  reg nxt_io_en;
  reg clk_en_ff;
  reg nxt_clk_en;
  reg rst_ff;
  reg nxt_rst;
  reg sel5_ff;
  reg off_n_ff;
  reg nxt_off_n;
  reg fault_latch_ff;
  reg vdd_low_d_ff;
  reg por_ff;
  reg present_d_ff;
  reg irq_ff;
  reg [`CFP_EV_W-1:0] ev_ff;
  reg [`CFP_EV_W-1:0] nxt_ev;
  reg [`CFP_EV_W-1:0] mask_ff;
  reg [4:0] cause_ff;
  reg [4:0] nxt_cause;

  wire present_deb;
  wire extract_pulse;
  wire in_session;
  wire removed;
  wire fault_now;
  wire osc_tick;
  wire half_t;
  wire state_change;
  wire deact_done;
  wire wr_en;
  wire rd_setup;
  wire [4:0] fault_src;

  function [4:0] w1c;
    input [4:0] cur;
    input [4:0] set;
    input clr_en;
    input [4:0] clr;
    begin
      // Hardware set beats a software clear in the same cycle
      w1c = (cur & ~(clr_en ? clr : 5'h00)) | set;
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `CFP_ADDR_STATUS) ||
               (addr == `CFP_ADDR_IRQ_STATUS) ||
               (addr == `CFP_ADDR_IRQ_MASK) ||
               (addr == `CFP_ADDR_FAULT_CAUSE);
    end
  endfunction

  cfp_debounce #(
    .DEB_CYCLES(DEB_CYCLES),
    .CW(18)
  ) u_deb (
    .pclk(pclk),
    .presetn(presetn),
    .raw(card_present_switch),
    .stable(present_deb),
    .fall_pulse(extract_pulse)
  );

  // Session qualification of every fault source
  assign in_session = state_ff[1] | state_ff[2];
  assign removed = extract_pulse | ~present_deb;
  assign fault_src[`CFP_FC_OVERCURRENT] = overcurrent;
  assign fault_src[`CFP_FC_OVERTEMP] = overtemp;
  assign fault_src[`CFP_FC_VDD_LOW] = vdd_low;
  assign fault_src[`CFP_FC_VCC_RANGE] = vcc_out_of_range;
  assign fault_src[`CFP_FC_REMOVED] = removed;
  assign fault_now = in_session & (|fault_src);

  // Internal oscillator always runs; no stop state is provided
  assign osc_tick = (div_ff == OSC_LAST);
  assign half_t = osc_tick & (tick_ff == `CFP_HALF_T_LAST);
  assign state_change = (nxt_state != state_ff);
  assign deact_done = state_ff[3] & nxt_state[0];

  // Oscillator divider and half-T step counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 8'h00;
      tick_ff <= 5'h00;
      step_ff <= 4'h0;
    end else if (state_change) begin
      // Restart timing so each phase is measured from its own entry
      div_ff <= 8'h00;
      tick_ff <= 5'h00;
      step_ff <= 4'h0;
    end else begin
      div_ff <= osc_tick ? 8'h00 : div_ff + 8'h01;
      if (osc_tick) begin
        tick_ff <= tick_ff + 5'h01;
      end
      if (half_t && step_ff != `CFP_STEP_MAX) begin
        step_ff <= step_ff + 4'h1;
      end
    end
  end

  // Session sequencer
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (!session_request_n && present_deb && !fault_latch_ff &&
            !vdd_low) begin
          nxt_state = ST_ACT;
        end
      end
      ST_ACT: begin
        if (fault_now || session_request_n) begin
          nxt_state = ST_DEACT;
        end else if (half_t && step_ff == `CFP_ACT_RST_STEP - 4'h1) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (fault_now || session_request_n) begin
          nxt_state = ST_DEACT;
        end
      end
      ST_DEACT: begin
        if (step_ff >= `CFP_DE_VCC_STEP && vcc_discharged) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Card contact controls
  always @* begin
    nxt_vcc_en = 1'b0;
    nxt_io_en = 1'b0;
    nxt_clk_en = 1'b0;
    nxt_rst = 1'b0;
    case (nxt_state)
      ST_ACT: begin
        nxt_vcc_en = (step_ff >= `CFP_ACT_VCC_STEP);
        nxt_io_en = (step_ff >= `CFP_ACT_IO_STEP);
        nxt_clk_en = (step_ff >= `CFP_ACT_IO_STEP);
      end
      ST_ACTIVE: begin
        nxt_vcc_en = 1'b1;
        nxt_io_en = 1'b1;
        nxt_clk_en = 1'b1;
        nxt_rst = host_reset_in;
      end
      ST_DEACT: begin
        // Reset drops first, the rest follow in half-T steps
        nxt_rst = 1'b0;
        nxt_clk_en = clk_en_ff & ~state_ff[3] |
                     clk_en_ff & (step_ff < `CFP_DE_CLK_STEP);
        nxt_io_en = io_en_ff & ~state_ff[3] |
                    io_en_ff & (step_ff < `CFP_DE_IO_STEP);
        nxt_vcc_en = vcc_en_ff & ~state_ff[3] |
                     vcc_en_ff & (step_ff < `CFP_DE_VCC_STEP);
      end
      default: begin
        nxt_vcc_en = 1'b0;
      end
    endcase
  end

  // Fault/absent output
  always @* begin
    if (fault_latch_ff || fault_now) begin
      nxt_off_n = 1'b0;
    end else if (extract_pulse) begin
      nxt_off_n = 1'b0;
    end else begin
      // Supply drop outside session does not enter here
      nxt_off_n = present_deb;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      vcc_en_ff <= 1'b0;
      io_en_ff <= 1'b0;
      clk_en_ff <= 1'b0;
      rst_ff <= 1'b0;
      sel5_ff <= 1'b0;
      off_n_ff <= 1'b0;
      fault_latch_ff <= 1'b0;
      vdd_low_d_ff <= 1'b0;
      por_ff <= 1'b0;
      present_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      vcc_en_ff <= nxt_vcc_en;
      io_en_ff <= nxt_io_en;
      clk_en_ff <= nxt_clk_en;
      rst_ff <= nxt_rst;
      // Level choice tracks the pin in every state
      sel5_ff <= supply_level_select;
      off_n_ff <= nxt_off_n;
      vdd_low_d_ff <= vdd_low;
      present_d_ff <= present_deb;
      por_ff <= vdd_low & ~vdd_low_d_ff & ~in_session;
      if (fault_now) begin
        fault_latch_ff <= 1'b1;
      end else if (state_ff[0] && session_request_n) begin
        // Held until the host has let go of the request
        fault_latch_ff <= 1'b0;
      end
    end
  end

  assign vcc_enable = vcc_en_ff;
  assign io_enable = io_en_ff;
  assign card_clk_enable = clk_en_ff;
  assign card_rst = rst_ff;
  assign vcc_sel_5v = sel5_ff;
  assign fault_absent_n = off_n_ff;
  assign por_pulse = por_ff;
  assign osc_fast = ~state_ff[0];

  // APB access, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & ~mapped(paddr);

  // Events and interrupt
  always @* begin
    nxt_ev = {`CFP_EV_W{1'b0}};
    nxt_ev[`CFP_EV_INSERT] = present_deb & ~present_d_ff;
    nxt_ev[`CFP_EV_EXTRACT] = extract_pulse;
    nxt_ev[`CFP_EV_FAULT] = fault_now & ~fault_latch_ff;
    nxt_ev[`CFP_EV_DEACT_DONE] = deact_done;
    nxt_ev[`CFP_EV_POR] = vdd_low & ~vdd_low_d_ff & ~in_session;
    nxt_cause = fault_now ? fault_src : 5'h00;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_ff <= `CFP_EV_RST;
      mask_ff <= `CFP_IRQ_MASK_RST;
      cause_ff <= 5'h00;
      irq_ff <= 1'b0;
    end else begin
      ev_ff <= w1c(ev_ff, nxt_ev,
                   wr_en && paddr == `CFP_ADDR_IRQ_STATUS, pwdata[4:0]);
      cause_ff <= w1c(cause_ff, nxt_cause,
                      wr_en && paddr == `CFP_ADDR_FAULT_CAUSE,
                      pwdata[4:0]);
      if (wr_en && paddr == `CFP_ADDR_IRQ_MASK) begin
        mask_ff <= pwdata[4:0];
      end
      irq_ff <= |(ev_ff & mask_ff);
    end
  end

  assign irq = irq_ff;

  // Read data captured in setup so it stands through the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        `CFP_ADDR_STATUS: begin
          prdata <= {23'h000000, sel5_ff, state_ff, fault_latch_ff,
                     in_session, off_n_ff, present_deb};
        end
        `CFP_ADDR_IRQ_STATUS: begin
          prdata <= {27'h0000000, ev_ff};
        end
        `CFP_ADDR_IRQ_MASK: begin
          prdata <= {27'h0000000, mask_ff};
        end
        `CFP_ADDR_FAULT_CAUSE: begin
          prdata <= {27'h0000000, cause_ff};
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule // cfp_card_ctrl

// file: cfp_defs.vh
`ifndef CFP_DEFS_VH
`define CFP_DEFS_VH

// Clock and timing
`define CFP_CLK_NS 40
`define CFP_T_NS 25000
`define CFP_T_OSC_PERIODS 64
`define CFP_OSC_DIV ((`CFP_T_NS / `CFP_T_OSC_PERIODS) / `CFP_CLK_NS)
`define CFP_HALF_T_LAST 5'h1f
`define CFP_DEB_MS 8
`define CFP_DEB_CYCLES ((`CFP_DEB_MS * 1000000) / `CFP_CLK_NS)

// Sequence marks in half-T steps
`define CFP_ACT_VCC_STEP 4'h3
`define CFP_ACT_IO_STEP 4'h8
`define CFP_ACT_RST_STEP 4'he
`define CFP_DE_CLK_STEP 4'h1
`define CFP_DE_IO_STEP 4'h2
`define CFP_DE_VCC_STEP 4'h3
`define CFP_STEP_MAX 4'hf

// Register offsets
`define CFP_ADDR_STATUS 8'h00
`define CFP_ADDR_IRQ_STATUS 8'h04
`define CFP_ADDR_IRQ_MASK 8'h08
`define CFP_ADDR_FAULT_CAUSE 8'h0c

// Event bits of irq status and mask
`define CFP_EV_INSERT 0
`define CFP_EV_EXTRACT 1
`define CFP_EV_FAULT 2
`define CFP_EV_DEACT_DONE 3
`define CFP_EV_POR 4
`define CFP_EV_W 5

// Fault cause bits
`define CFP_FC_OVERCURRENT 0
`define CFP_FC_OVERTEMP 1
`define CFP_FC_VDD_LOW 2
`define CFP_FC_VCC_RANGE 3
`define CFP_FC_REMOVED 4

// Reset values
`define CFP_IRQ_MASK_RST 5'h00
`define CFP_EV_RST 5'h00

`endif

// file: cfp_debounce.v
`timescale 1ns/1ns
`include "cfp_defs.vh"

module cfp_debounce #(
  parameter DEB_CYCLES = `CFP_DEB_CYCLES,
  parameter CW = 18
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Switch side
  input wire raw,
  // Filtered side
  output wire stable,
  output wire fall_pulse
);

  localparam [31:0] DEB_W = DEB_CYCLES;
  localparam [CW-1:0] DEB_LAST = DEB_W[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

  reg raw_d_ff;
  reg stable_ff;
  reg [CW-1:0] cnt_ff;

  // Release acts at once, no filtering on the way out
  assign fall_pulse = raw_d_ff & ~raw;
  assign stable = stable_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_d_ff <= 1'b0;
      stable_ff <= 1'b0;
      cnt_ff <= {CW{1'b0}};
    end else begin
      raw_d_ff <= raw;
      if (!raw) begin
        stable_ff <= 1'b0;
        cnt_ff <= {CW{1'b0}};
      end else if (cnt_ff == DEB_LAST) begin
        stable_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // cfp_debounce

// file: cfp_card_ctrl_properties.sv
`timescale 1ns/1ns
module cfp_props #(
  parameter DEB_CYCLES = 20,
  parameter OSC_DIV = 1
) (
  // Clock, reset and inputs
  input wire pclk,
  input wire presetn,
  input wire session_request_n,
  input wire supply_level_select,
  input wire card_present_switch,
  input wire overcurrent,
  input wire overtemp,
  input wire vdd_low,
  // Outputs
  input wire fault_absent_n,
  input wire vcc_enable,
  input wire vcc_sel_5v,
  input wire io_enable,
  input wire card_clk_enable,
  input wire card_rst,
  input wire osc_fast,
  input wire por_pulse
);
  localparam int HT = OSC_DIV * 32;
  int stab_ff;
  int act_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycle counts since switch high and since leaving idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_ff <= 0;
      act_ff <= 0;
    end else begin
      stab_ff <= card_present_switch ? stab_ff + 1 : 0;
      act_ff <= osc_fast ? act_ff + 1 : 0;
    end
  end
  por_pulse_a:
    assert property ($rose(vdd_low) && !osc_fast |-> ##[1:2] por_pulse)
    else $error("no reset pulse");
  idle_fault_a:
    assert property (!osc_fast && session_request_n && fault_absent_n
      && card_present_switch && $stable(card_present_switch)
      |=> fault_absent_n) else $error("idle output dropped");
  sess_fault_a:
    assert property (io_enable && !session_request_n
      && (overcurrent || overtemp) |-> ##[1:2] !fault_absent_n)
    else $error("fault not reported");
  extract_a:
    assert property ($fell(card_present_switch) && fault_absent_n
      |-> ##[1:3] !fault_absent_n) else $error("late extraction");
  insert_wait_a:
    assert property ($rose(fault_absent_n) |-> stab_ff >= DEB_CYCLES)
    else $error("debounce too short");
  idle_present_a:
    assert property (!osc_fast && session_request_n
      && stab_ff > DEB_CYCLES + 8 |-> ##[0:3] fault_absent_n)
    else $error("presence not shown");
  sel_track_a:
    assert property ($changed(supply_level_select)
      |=> vcc_sel_5v == $past(supply_level_select))
    else $error("supply select lost");
  vcc_time_a:
    assert property ($rose(vcc_enable) |-> act_ff >= 3 * HT
      && act_ff <= 3 * HT + 2) else $error("supply ramp time");
  deact_order_a:
    assert property ($fell(vcc_enable)
      |-> !io_enable && !card_clk_enable && !card_rst)
    else $error("deactivation order");
  cover property ($rose(card_rst));
  cover property ($fell(fault_absent_n) && io_enable);
  cover property (por_pulse);
endmodule // cfp_props

bind cfp_card_ctrl cfp_props #(.DEB_CYCLES(DEB_CYCLES), .OSC_DIV(OSC_DIV))
  cfp_props_i (.pclk, .presetn, .session_request_n, .supply_level_select,
  .card_present_switch, .overcurrent, .overtemp, .vdd_low, .fault_absent_n,
  .vcc_enable, .vcc_sel_5v, .io_enable, .card_clk_enable, .card_rst,
  .osc_fast, .por_pulse);

// file: cfp_host_model.sv
`timescale 1ns/1ns
module cfp_host_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bench commands
  input wire want,
  input wire atr,
  // Device lines
  input wire fault_absent_n,
  output reg session_request_n,
  output reg host_reset_in
);
  reg held_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      session_request_n <= 1'b1;
      held_ff <= 1'b0;
      host_reset_in <= 1'b0;
    end else begin
      // Off until the bench asks anew, so the output can be reread
      if (!session_request_n && !fault_absent_n) begin
        session_request_n <= 1'b1;
        held_ff <= 1'b1;
      end else begin
        session_request_n <= !(want && !held_ff);
        held_ff <= held_ff && want;
      end
      host_reset_in <= atr;
    end
  end
endmodule // cfp_host_model

// file: cfp_card_ctrl_test.sv
`timescale 1ns/1ns
module cfp_card_ctrl_test;
  localparam int HT = 32;
  localparam int DEB = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic want = 0, atr = 0, supply_level_select = 0;
  logic card_present_switch = 0, vcc_discharged = 1;
  logic [3:0] flt = 0;
  wire [31:0] prdata;
  wire pready, pslverr, fault_absent_n, vcc_enable, vcc_sel_5v, io_enable;
  wire card_clk_enable, card_rst, osc_fast, por_pulse, irq;
  wire session_request_n, host_reset_in;
  int n_fail = 0, checked = 0, n, k;
  cfp_card_ctrl #(.DEB_CYCLES(DEB), .OSC_DIV(1)) cfp_card_ctrl_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .session_request_n, .supply_level_select, .host_reset_in,
    .fault_absent_n, .card_present_switch, .overcurrent(flt[0]),
    .overtemp(flt[1]), .vdd_low(flt[2]), .vcc_out_of_range(flt[3]),
    .vcc_discharged, .vcc_enable, .vcc_sel_5v, .io_enable, .card_clk_enable,
    .card_rst, .osc_fast, .por_pulse, .irq);
  cfp_host_model cfp_host_model_i (.pclk, .presetn, .want, .atr,
    .fault_absent_n, .session_request_n, .host_reset_in);
  always #20 pclk = ~pclk;
  // Card supply settles as soon as it is switched off
  always @(posedge pclk) vcc_discharged <= !vcc_enable;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(e, xe);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return vcc_enable;
      1: return card_rst;
      2: return osc_fast;
      default: return fault_absent_n;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic v, output int c);
    c = 0;
    while (pick(w) !== v && c < 4000) begin
      @(posedge pclk);
      c++;
    end
    // A limit that runs out counts as a mismatch
    chk(pick(w), v);
  endtask
  task automatic activate;
    int c;
    want <= 1'b1;
    atr <= 1'b0;
    wait_for(0, 1'b1, c);
    atr <= 1'b1;
    wait_for(1, 1'b1, c);
    chk(c >= 11 * HT - 3 && c <= 11 * HT + 4, 1);
  endtask
  task give_verdict;
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(fault_absent_n, 0);
    rd(8'h08, 32'h0, 1'b0);
    wr(8'h08, 32'h1f);
    rd(8'h08, 32'h1f, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    // Bouncing insertion, each bounce restarts the filter
    for (k = 0; k < 7; k++) begin
      card_present_switch <= ~k[0];
      @(posedge pclk);
    end
    repeat (DEB - 3) @(posedge pclk);
    chk(fault_absent_n, 0);
    wait_for(3, 1'b1, n);
    chk(n < 8, 1);
    wr(8'h04, 32'h1f);
    wr(8'h08, 32'h0);
    flt <= 4'h3;
    repeat (4) @(posedge pclk);
    flt <= 4'h4;
    repeat (4) @(posedge pclk);
    flt <= 4'h0;
    repeat (2) @(posedge pclk);
    chk(fault_absent_n, 1);
    chk(irq, 0);
    rd(8'h0c, 32'h0, 1'b0);
    rd(8'h04, 32'h10, 1'b0);
    wr(8'h08, 32'h10);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    wr(8'h04, 32'h10);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    supply_level_select <= 1'b1;
    rd(8'h00, 32'h113, 1'b0);
    chk(vcc_sel_5v, 1);
    for (k = 0; k < 4; k++) begin
      activate;
      chk({io_enable, card_clk_enable}, 2'b11);
      supply_level_select <= k[0];
      repeat (2) @(posedge pclk);
      chk(vcc_sel_5v, k[0]);
      flt <= 4'h1 << k;
      @(posedge pclk);
      flt <= 4'h0;
      wait_for(3, 1'b0, n);
      chk(n < 4, 1);
      wait_for(2, 1'b0, n);
      want <= 1'b0;
      wait_for(3, 1'b1, n);
      chk(n < 6, 1);
      rd(8'h0c, 32'h1 << k, 1'b0);
      wr(8'h0c, 32'h1f);
    end
    activate;
    want <= 1'b0;
    wait_for(1, 1'b0, n);
    chk(n < 5, 1);
    wait_for(0, 1'b0, n);
    chk(n >= 3 * HT - 3 && n <= 3 * HT + 3, 1);
    wait_for(2, 1'b0, n);
    chk(fault_absent_n, 1);
    activate;
    card_present_switch <= 1'b0;
    wait_for(3, 1'b0, n);
    chk(n < 5, 1);
    wait_for(2, 1'b0, n);
    want <= 1'b0;
    repeat (DEB + 5) @(posedge pclk);
    chk(fault_absent_n, 0);
    give_verdict;
  end
endmodule // cfp_card_ctrl_test
